/* File: hdl/wakeup_interrupt_dispatch.sv */
// Wake-up and interrupt dispatch with APB register access
`timescale 1ns/1ps
module wakeup_interrupt_dispatch
  import wake_irq_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  input  wire logic                    soft_rst_req,
  input  wire wake_irq_pkg::event_t    events,
  input  wire wake_irq_pkg::instr_t    instr,
  input  wire wake_irq_pkg::ctx_t      ctx_in,
  output wake_irq_pkg::ctx_t           ctx_out,
  output logic                         ctx_restore,
  output wake_irq_pkg::dispatch_t      dispatch,
  output logic                         sleeping,
  output logic                         clocks_run,
  output logic                         conv_stop,
  output logic                         global_irq_en
);
  import wake_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mode_t      mode;
    logic       gie;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] wake;
    logic [7:0] wdog;
    logic [7:0] ctrl;
    logic [7:0] conv;
    logic [7:0] status;
    ctx_t       saved;
    dispatch_t  disp;
    logic       restore;
    logic       conv_stop;
    logic [7:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero-wait slave, error on unmapped index

  logic        acc_phase;
  logic        wr_hit;
  logic [7:0]  idx;
  logic        mapped;
  logic [7:0]  wd;

  assign acc_phase = psel && penable;
  assign idx       = paddr[9:2];
  assign wd        = pwdata[7:0];
  assign mapped    = (idx == IDX_CORE_STATUS) || (idx == IDX_WAKE_CTRL)
                  || (idx == IDX_FLAG_BANK) || (idx == IDX_WDT_MASK_TWO)
                  || (idx == IDX_MASK_BANK) || (idx == IDX_CORE_CONTROL)
                  || (idx == IDX_CONV_CONTROL) || (idx == IDX_DISPATCH);
  assign wr_hit    = acc_phase && pwrite && mapped;
  assign pready    = 1'b1;
  assign pslverr   = acc_phase && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification per source, priority order

  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] pend;
  logic [9:0]      vec_tab [NSRC];

  assign raw = {events.aux_c, events.aux_b, events.aux_a, events.low_pulse,
                events.high_pulse, events.conv_done, events.main_timer,
                events.pin_change, events.ext_pin};
  assign en  = {st_r.mask[B_AUX_C], st_r.mask[B_AUX_B], st_r.mask[B_AUX_A],
                st_r.mask[B_LOW_PULSE], st_r.mask[B_HIGH_PULSE],
                st_r.wdog[B_CONV_IRQ_EN], st_r.mask[B_MAIN_TIMER],
                st_r.mask[B_PIN_CHANGE], st_r.mask[B_EXT_PIN]};
  assign pend = {st_r.flags[B_AUX_C], st_r.flags[B_AUX_B], st_r.flags[B_AUX_A],
                 st_r.flags[B_LOW_PULSE], st_r.flags[B_HIGH_PULSE],
                 st_r.wake[B_CONV_FLAG], st_r.flags[B_MAIN_TIMER],
                 st_r.flags[B_PIN_CHANGE], st_r.flags[B_EXT_PIN]} & en;

  assign vec_tab[S_EXT]  = VEC_EXT;
  assign vec_tab[S_PC]   = VEC_PC;
  assign vec_tab[S_TMR]  = VEC_TMR;
  assign vec_tab[S_CONV] = VEC_CONV;
  assign vec_tab[S_HP]   = VEC_HP;
  assign vec_tab[S_LP]   = VEC_LP;
  assign vec_tab[S_A]    = VEC_A;
  assign vec_tab[S_B]    = VEC_B;
  assign vec_tab[S_C]    = VEC_C;

  // Highest pending source wins; lower index first
  logic [9:0] win_vec;
  logic       any_pend;
  always_comb begin
    win_vec  = VEC_RESET;
    any_pend = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win_vec  = vec_tab[i];
        any_pend = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic in_sleep;
  logic wdog_fire;
  logic pc_wake;
  logic conv_wake;
  logic wake_now;
  logic pc_flag_ok;

  assign in_sleep   = (st_r.mode == MODE_SLEEP);
  assign wdog_fire  = events.wdog_timeout && st_r.wdog[B_WDOG_EN];
  assign pc_wake    = in_sleep && events.pin_change && st_r.wake[B_PC_WAKE];
  assign conv_wake  = in_sleep && events.conv_done && st_r.wake[B_CONV_WAKE];
  assign wake_now   = pc_wake || conv_wake;
  // Pin change flag needs its own enable in every mode; others, except the converter flag, always latch
  assign pc_flag_ok = events.pin_change && st_r.mask[B_PIN_CHANGE];

  always_comb begin
    st_nxt           = st_r;
    st_nxt.disp      = '0;
    st_nxt.restore   = 1'b0;
    st_nxt.rdata     = RST_ZERO;

    // Software writes; a write of zero clears a flag
    if (wr_hit) begin
      if (idx == IDX_WAKE_CTRL) begin
        st_nxt.wake = wd;
      end else if (idx == IDX_FLAG_BANK) begin
        st_nxt.flags = wd;
      end else if (idx == IDX_WDT_MASK_TWO) begin
        st_nxt.wdog = wd;
      end else if (idx == IDX_MASK_BANK) begin
        st_nxt.mask = wd;
      end else if (idx == IDX_CORE_CONTROL) begin
        st_nxt.ctrl = wd;
      end else if (idx == IDX_CONV_CONTROL) begin
        // Run bit can be set by software but never cleared by it
        st_nxt.conv = {wd[7:5], st_r.conv[B_CONV_RUN] | wd[B_CONV_RUN], wd[3:0]};
      end else if (idx == IDX_CORE_STATUS) begin
        st_nxt.status = {st_r.status[7:5], wd[4:0]};
      end
    end

    // Hardware sets win over a same-cycle software clear
    if (events.ext_pin)    st_nxt.flags[B_EXT_PIN]    = 1'b1;
    if (events.main_timer) st_nxt.flags[B_MAIN_TIMER] = 1'b1;
    if (events.high_pulse) st_nxt.flags[B_HIGH_PULSE] = 1'b1;
    if (events.low_pulse)  st_nxt.flags[B_LOW_PULSE]  = 1'b1;
    if (events.aux_a)      st_nxt.flags[B_AUX_A]      = 1'b1;
    if (events.aux_b)      st_nxt.flags[B_AUX_B]      = 1'b1;
    if (events.aux_c)      st_nxt.flags[B_AUX_C]      = 1'b1;
    if (pc_flag_ok)        st_nxt.flags[B_PIN_CHANGE] = 1'b1;
    if (events.conv_done) begin
      st_nxt.conv[B_CONV_RUN] = 1'b0;  // Run clears on completion
      if (st_r.wdog[B_CONV_IRQ_EN]) st_nxt.wake[B_CONV_FLAG] = 1'b1;
    end

    // Global enable
    if (instr.irq_on || instr.reti) st_nxt.gie = 1'b1;
    if (instr.irq_off)              st_nxt.gie = 1'b0;
    if (instr.wdog_clear) begin
      st_nxt.status[B_ST_T] = 1'b1;
      st_nxt.status[B_ST_P] = 1'b1;
    end

    st_nxt.conv_stop = 1'b0;
    case (st_r.mode)
      MODE_NORMAL, MODE_ISR: begin
        if (instr.reti && st_r.mode == MODE_ISR) begin
          st_nxt.mode    = MODE_NORMAL;
          st_nxt.restore = 1'b1;
        end else if (instr.sleep) begin
          st_nxt.mode = MODE_SLEEP;
          st_nxt.status[B_ST_T] = 1'b1;
          st_nxt.status[B_ST_P] = 1'b0;
          // Converter idle in sleep unless it may wake or flag
          if (!st_r.wake[B_CONV_WAKE] && !st_r.wdog[B_CONV_IRQ_EN]) begin
            st_nxt.conv[B_CONV_RUN] = 1'b0;
            st_nxt.conv_stop        = 1'b1;
          end
        end else if (st_r.gie && any_pend) begin
          // Vector: save context, mask further nesting until return
          st_nxt.mode        = MODE_ISR;
          st_nxt.gie         = 1'b0;
          st_nxt.saved       = ctx_in;
          st_nxt.disp.take   = 1'b1;
          st_nxt.disp.vector = win_vec;
        end
      end
      MODE_SLEEP: begin
        if (events.conv_done && !st_r.wake[B_CONV_WAKE]) begin
          st_nxt.conv_stop = 1'b1;
        end
        if (wake_now) begin
          st_nxt.mode = MODE_NORMAL;
          st_nxt.disp.resume = 1'b1;
          if (pc_wake) begin
            st_nxt.status[B_ST_PINWAKE] = 1'b1;
          end
          // Vector taken on the following cycle by the normal branch
        end
      end
      default: st_nxt.mode = MODE_NORMAL;
    endcase

    // Watchdog: wake if asleep, then reset to address zero
    if (wdog_fire) begin
      st_nxt               = st_r;
      st_nxt.disp          = '0;
      st_nxt.restore       = 1'b0;
      st_nxt.rdata         = RST_ZERO;
      st_nxt.conv_stop     = 1'b0;
      st_nxt.mode          = MODE_NORMAL;
      st_nxt.disp.soft_reset = 1'b1;
      st_nxt.disp.vector   = VEC_RESET;
      st_nxt.disp.resume   = in_sleep;
    end
    if (wdog_fire || soft_rst_req) begin
      st_nxt.gie    = 1'b0;
      st_nxt.flags  = RST_ZERO;
      st_nxt.mask   = RST_ZERO;
      st_nxt.wake   = RST_ZERO;
      st_nxt.wdog   = RST_ZERO;
      st_nxt.conv   = RST_ZERO;
      st_nxt.ctrl   = RST_CORE_CONTROL;
      // Watchdog clears T and keeps P, so software can tell sleep from run
      st_nxt.status = {3'b000, 1'b0, st_r.status[B_ST_P], st_r.status[2:0]};
      if (soft_rst_req) begin
        st_nxt.mode            = MODE_NORMAL;
        st_nxt.disp.soft_reset = 1'b1;
        st_nxt.disp.vector     = VEC_RESET;
        st_nxt.status[B_ST_T]  = in_sleep ? 1'b1 : st_r.status[B_ST_T];
        st_nxt.status[B_ST_P]  = in_sleep ? 1'b0 : st_r.status[B_ST_P];
      end
    end

    // Read data captured in setup so it stands during access
    if (psel && !penable && !pwrite) begin
      if (idx == IDX_CORE_STATUS) begin
        st_nxt.rdata = st_r.status;
      end else if (idx == IDX_WAKE_CTRL) begin
        st_nxt.rdata = st_r.wake;
      end else if (idx == IDX_FLAG_BANK) begin
        st_nxt.rdata = st_r.flags;
      end else if (idx == IDX_WDT_MASK_TWO) begin
        st_nxt.rdata = st_r.wdog;
      end else if (idx == IDX_MASK_BANK) begin
        st_nxt.rdata = st_r.mask;
      end else if (idx == IDX_CORE_CONTROL) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (idx == IDX_CONV_CONTROL) begin
        st_nxt.rdata = st_r.conv;
      end else if (idx == IDX_DISPATCH) begin
        st_nxt.rdata = {5'b00000, st_r.gie, st_r.mode};
      end
    end
  end

  // Registered state; power-on values only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r        <= '0;
      st_r.mode   <= MODE_NORMAL;
      st_r.ctrl   <= RST_CORE_CONTROL;
      st_r.status <= 8'h18;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata        = {24'h000000, st_r.rdata};
  assign ctx_out       = st_r.saved;
  assign ctx_restore   = st_r.restore;
  assign dispatch      = st_r.disp;
  assign sleeping      = in_sleep;
  // Clocks stop in sleep unless a conversion may wake us
  assign clocks_run    = !in_sleep || st_r.wake[B_CONV_WAKE];
  assign conv_stop     = st_r.conv_stop;
  assign global_irq_en = st_r.gie;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_TIMER_NO_WAKE: assert property (@(posedge clk) disable iff (!arst_n)
    in_sleep && events.main_timer && !events.pin_change && !events.conv_done
    && !wdog_fire && !soft_rst_req |=> sleeping)
    else $error("main timer woke the device");
  AST_PC_NOWAKE_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
    in_sleep && events.pin_change && !st_r.wake[B_PC_WAKE] && st_r.mask[B_PIN_CHANGE]
    && !wdog_fire && !soft_rst_req && !events.conv_done
    |=> sleeping && st_r.flags[B_PIN_CHANGE] && !clocks_run)
    else $error("pin change flag or sleep wrong");
  AST_PC_WAKE_NOFLAG: assert property (@(posedge clk) disable iff (!arst_n)
    in_sleep && events.pin_change && st_r.wake[B_PC_WAKE] && !st_r.mask[B_PIN_CHANGE]
    && !st_r.flags[B_PIN_CHANGE] && !wdog_fire && !soft_rst_req && !(wr_hit && idx == IDX_FLAG_BANK)
    |=> !sleeping && dispatch.resume && !st_r.flags[B_PIN_CHANGE])
    else $error("pin change wake wrong");
  AST_PC_VECTOR: assert property (@(posedge clk) disable iff (!arst_n)
    in_sleep && st_r.gie && events.pin_change && st_r.wake[B_PC_WAKE]
    && st_r.mask[B_PIN_CHANGE] && pend[S_EXT:S_EXT] == 1'b0 && !wdog_fire && !soft_rst_req
    && !instr.irq_off && !(wr_hit)
    |=> ##1 dispatch.take && dispatch.vector == 10'h006)
    else $error("wake did not vector to 006H");
  AST_WDOG_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    wdog_fire |=> dispatch.soft_reset && dispatch.vector == 10'h000 && st_r.mask == 8'h00)
    else $error("watchdog did not reset");
  AST_GIE_ON: assert property (@(posedge clk) disable iff (!arst_n)
    instr.irq_on && !instr.irq_off && !wdog_fire && !soft_rst_req && !in_sleep
    && !any_pend |=> global_irq_en)
    else $error("enable instruction ignored");
  AST_PRIORITY: assert property (@(posedge clk) disable iff (!arst_n)
    st_r.mode == MODE_NORMAL && st_r.gie && pend[S_EXT] && !instr.sleep && !instr.reti
    && !wdog_fire && !soft_rst_req |=> dispatch.vector == 10'h003)
    else $error("external source not served first");
  AST_SLEEP_CONV_STOP: assert property (@(posedge clk) disable iff (!arst_n)
    st_r.mode == MODE_NORMAL && instr.sleep && !instr.reti && !st_r.wake[B_CONV_WAKE]
    && !st_r.wdog[B_CONV_IRQ_EN] && !wr_hit && !wdog_fire && !soft_rst_req
    |=> conv_stop && !st_r.conv[B_CONV_RUN] && sleeping)
    else $error("converter not stopped on sleep entry");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    st_r.flags[B_AUX_A] && !wr_hit && !wdog_fire && !soft_rst_req |=> st_r.flags[B_AUX_A])
    else $error("flag dropped without software clear");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!arst_n)
    st_r.mode == MODE_ISR && instr.reti && !wdog_fire && !soft_rst_req
    |=> ctx_restore ##1 !ctx_restore)
    else $error("context not restored on return");

endmodule : wakeup_interrupt_dispatch

/* File: hdl/wake_irq_pkg.sv */
// Package: register map, field positions, vectors and types for the wake-up/interrupt dispatch
package wake_irq_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_CORE_STATUS   = 8'h03;
  localparam logic [7:0]  IDX_WAKE_CTRL     = 8'h0E;
  localparam logic [7:0]  IDX_FLAG_BANK     = 8'h0F;
  localparam logic [7:0]  IDX_WDT_MASK_TWO  = 8'h10;
  localparam logic [7:0]  IDX_MASK_BANK     = 8'h11;
  localparam logic [7:0]  IDX_CORE_CONTROL  = 8'h12;
  localparam logic [7:0]  IDX_CONV_CONTROL  = 8'h09;
  localparam logic [7:0]  IDX_DISPATCH      = 8'h13;

  // Reset values
  localparam logic [7:0]  RST_ZERO          = 8'h00;
  localparam logic [7:0]  RST_CORE_CONTROL  = 8'hB0;

  // Field positions: mask bank and flag bank share one layout
  localparam int          B_MAIN_TIMER      = 0;
  localparam int          B_PIN_CHANGE      = 1;
  localparam int          B_EXT_PIN         = 2;
  localparam int          B_AUX_A           = 3;
  localparam int          B_AUX_B           = 4;
  localparam int          B_AUX_C           = 5;
  localparam int          B_HIGH_PULSE      = 6;
  localparam int          B_LOW_PULSE       = 7;
  // Wake control register fields
  localparam int          B_PC_WAKE         = 1;
  localparam int          B_CONV_WAKE       = 3;
  localparam int          B_CONV_FLAG       = 5;
  // Watchdog control / second mask fields
  localparam int          B_CONV_IRQ_EN     = 5;
  localparam int          B_WDOG_EN         = 7;
  // Conversion control run bit
  localparam int          B_CONV_RUN        = 4;
  // Core status: reset cause bits
  localparam int          B_ST_PINWAKE      = 7;
  localparam int          B_ST_T            = 4;
  localparam int          B_ST_P            = 3;

  // Source numbering in priority order, 0 = highest
  localparam int          NSRC              = 9;
  localparam int          S_EXT = 0, S_PC = 1, S_TMR = 2, S_CONV = 3, S_HP = 4;
  localparam int          S_LP = 5, S_A = 6, S_B = 7, S_C = 8;

  // Vector addresses
  localparam logic [9:0]  VEC_RESET         = 10'h000;
  localparam logic [9:0]  VEC_EXT           = 10'h003;
  localparam logic [9:0]  VEC_PC            = 10'h006;
  localparam logic [9:0]  VEC_TMR           = 10'h009;
  localparam logic [9:0]  VEC_CONV          = 10'h00C;
  localparam logic [9:0]  VEC_HP            = 10'h012;
  localparam logic [9:0]  VEC_LP            = 10'h015;
  localparam logic [9:0]  VEC_A             = 10'h018;
  localparam logic [9:0]  VEC_B             = 10'h01B;
  localparam logic [9:0]  VEC_C             = 10'h01E;

  // APB
  localparam logic [31:0] APB_ZERO          = 32'h0000_0000;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_ISR} mode_t;

  // Event strobes from peripherals and core, one cycle each
  typedef struct packed {
    logic       ext_pin;
    logic       pin_change;
    logic       main_timer;
    logic       conv_done;
    logic       high_pulse;
    logic       low_pulse;
    logic       aux_a;
    logic       aux_b;
    logic       aux_c;
    logic       wdog_timeout;
  } event_t;

  // Instruction strobes from the sequencer
  typedef struct packed {
    logic       irq_on;
    logic       irq_off;
    logic       sleep;
    logic       reti;
    logic       wdog_clear;
  } instr_t;

  // Context saved on entry to a service routine
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] status;
    logic [7:0] ram_sel;
  } ctx_t;

  // Dispatch request to the sequencer
  typedef struct packed {
    logic       take;
    logic [9:0] vector;
    logic       resume;
    logic       soft_reset;
  } dispatch_t;

endpackage : wake_irq_pkg

/* File: tb/core_model.sv */
// Core sequencer stand-in: supplies context and returns from each service routine
`timescale 1ns/1ps
module core_model
  import wake_irq_pkg::*;
#(
  parameter int DLY = 16
)(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire wake_irq_pkg::dispatch_t dispatch,
  output wake_irq_pkg::ctx_t           ctx,
  output logic                         reti
);
  import wake_irq_pkg::*;
  logic [5:0] cnt_r;
  // Context moves every cycle so a stale capture is visible; routine length is DLY
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      reti  <= 1'b0;
      ctx   <= '0;
    end else begin
      ctx  <= ctx + 24'h010203;
      reti <= (cnt_r == 6'd1);
      if (dispatch.take) begin
        cnt_r <= 6'(DLY);
      end else if (cnt_r != 6'd0) begin
        cnt_r <= cnt_r - 6'd1;
      end
    end
  end
endmodule : core_model

/* File: tb/wakeup_interrupt_dispatch_tb.sv */
// Self-checking bench: registers, vectoring, priority, sleep and reset paths
`timescale 1ns/1ps
module wakeup_interrupt_dispatch_tb;
  import wake_irq_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, soft_rst_req, rt;
  logic sleeping, clocks_run, conv_stop, gie, ctx_restore;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  event_t ev_s;
  instr_t ins_s, inw;
  ctx_t ctx_in, ctx_out, pctx;
  dispatch_t dsp;
  int num_errors, comparisons, takes, srst, rsm, t0;
  logic [9:0] lvec;
  localparam int MB[9] = '{2, 1, 0, 5, 6, 7, 3, 4, 5};
  localparam logic [9:0] VT[9] = '{VEC_EXT, VEC_PC, VEC_TMR, VEC_CONV, VEC_HP, VEC_LP,
                                   VEC_A, VEC_B, VEC_C};
  assign inw = instr_t'(ins_s | {3'b000, rt, 1'b0});
  wakeup_interrupt_dispatch wakeup_interrupt_dispatch_i (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .soft_rst_req(soft_rst_req),
    .events(ev_s), .instr(inw), .ctx_in(ctx_in), .ctx_out(ctx_out),
    .ctx_restore(ctx_restore), .dispatch(dsp), .sleeping(sleeping),
    .clocks_run(clocks_run), .conv_stop(conv_stop), .global_irq_en(gie));
  core_model core_model_i (.clk(clk), .arst_n(arst_n), .dispatch(dsp), .ctx(ctx_in),
    .reti(rt));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Dispatch outputs stand one cycle, so count them mid-cycle
  always @(negedge clk) begin
    if (dsp.take === 1'b1) begin
      takes++;
      lvec = dsp.vector;
      chk("saved context", {8'h00, pctx}, {8'h00, ctx_out});
    end
    if (dsp.soft_reset === 1'b1) srst++;
    if (dsp.resume === 1'b1) rsm++;
    // Context the core showed in the cycle before a take is what must be saved
    pctx = ctx_in;
  end
  function automatic logic [7:0] fbit(input int s);
    return 8'h01 << MB[s];
  endfunction : fbit
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // One APB transfer; data and error are taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk($sformatf("reg %h", idx), {24'h0, x}, r);
  endtask : rdc
  task automatic ev(input event_t e);
    @(posedge clk);
    ev_s <= e;
    @(posedge clk);
    ev_s <= '0;
  endtask : ev
  task automatic ins(input instr_t i);
    @(posedge clk);
    ins_s <= i;
    @(posedge clk);
    ins_s <= '0;
  endtask : ins
  task automatic wtake();
    int n;
    n = 0;
    while (takes == t0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) num_errors++;
  endtask : wtake
  // One source end to end; with global enable off it must only flag
  task automatic do_src(input int s, input bit g);
    logic [7:0] mi, fi;
    mi = (s == S_CONV) ? IDX_WDT_MASK_TWO : IDX_MASK_BANK;
    fi = (s == S_CONV) ? IDX_WAKE_CTRL : IDX_FLAG_BANK;
    wr(mi, fbit(s));
    ins(g ? instr_t'(5'b10000) : instr_t'(5'b01000));
    t0 = takes;
    ev(event_t'(10'h200 >> s));
    if (g) begin
      wtake();
      chk("vector", {22'h0, VT[s]}, {22'h0, lvec});
      rdc(fi, fbit(s));
      wr(fi, 8'h00);
      repeat (16) @(posedge clk);
      chk("gie after return", 32'h1, {31'h0, gie});
    end else begin
      repeat (6) @(posedge clk);
      chk("no take", t0, takes);
      rdc(fi, fbit(s));
      wr(fi, 8'h00);
    end
    wr(mi, 8'h00);
  endtask : do_src
  initial begin
    #(25ns * 40000);
    num_errors++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic e;
    {arst_n, psel, penable, pwrite, soft_rst_req} = '0;
    {paddr, pwdata, ev_s, ins_s} = '0;
    {num_errors, comparisons, takes, srst, rsm} = '0;
    void'($urandom(32'h05C9));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rdc(IDX_CORE_CONTROL, RST_CORE_CONTROL);
    rdc(IDX_CORE_STATUS, 8'h18);
    foreach (VT[i]) if (i < 4) rdc(i[0] ? IDX_MASK_BANK : (i[1] ? IDX_WAKE_CTRL : IDX_FLAG_BANK), 8'h00);
    rdc(IDX_WDT_MASK_TWO, 8'h00);
    apb(1'b0, 8'h20, 8'h00, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    for (int s = 0; s < NSRC; s++) do_src(s, 1'b1);
    repeat (6) do_src($urandom_range(8, 0), 1'($urandom_range(1, 0)));
    // Two sources at once: the higher one is served first
    wr(IDX_MASK_BANK, 8'h24);
    ins(instr_t'(5'b10000));
    t0 = takes;
    ev(event_t'(10'h202));
    wtake();
    chk("first vector", {22'h0, VEC_EXT}, {22'h0, lvec});
    t0 = takes;
    wr(IDX_FLAG_BANK, 8'h20);
    wtake();
    chk("second vector", {22'h0, VEC_C}, {22'h0, lvec});
    wr(IDX_FLAG_BANK, 8'h00);
    wr(IDX_MASK_BANK, 8'h00);
    repeat (20) @(posedge clk);
    // Pin change wake with its interrupt off resumes without a flag
    wr(IDX_WAKE_CTRL, 8'h02);
    ins(instr_t'(5'b00100));
    repeat (3) @(posedge clk);
    chk("clocks in sleep", 32'h0, {31'h0, clocks_run});
    t0 = rsm;
    ev(event_t'(10'h100));
    repeat (4) @(posedge clk);
    chk("awake", 32'h0, {31'h0, sleeping});
    chk("resume", t0 + 1, rsm);
    rdc(IDX_FLAG_BANK, 8'h00);
    rdc(IDX_CORE_STATUS, 8'h90);
    rdc(IDX_WAKE_CTRL, 8'h02);
    // Interrupt on but wake off: flag only, stays asleep
    wr(IDX_WAKE_CTRL, 8'h00);
    wr(IDX_MASK_BANK, 8'h02);
    ins(instr_t'(5'b00100));
    ev(event_t'(10'h100));
    repeat (5) @(posedge clk);
    chk("still asleep", 32'h1, {31'h0, sleeping});
    rdc(IDX_FLAG_BANK, 8'h02);
    rdc(IDX_MASK_BANK, 8'h02);
    // Both change enables on with global enable: wake, then vector
    wr(IDX_FLAG_BANK, 8'h00);
    wr(IDX_WAKE_CTRL, 8'h02);
    t0 = takes;
    ev(event_t'(10'h100));
    wtake();
    chk("wake vector", {22'h0, VEC_PC}, {22'h0, lvec});
    rdc(IDX_FLAG_BANK, 8'h02);
    wr(IDX_FLAG_BANK, 8'h00);
    repeat (20) @(posedge clk);
    @(posedge clk);
    soft_rst_req <= 1'b1;
    @(posedge clk);
    soft_rst_req <= 1'b0;
    repeat (4) @(posedge clk);
    rdc(IDX_FLAG_BANK, 8'h00);
    rdc(IDX_MASK_BANK, 8'h00);
    // Enabled watchdog timeout resets to address zero
    t0 = srst;
    wr(IDX_WDT_MASK_TWO, 8'h80);
    ev(event_t'(10'h001));
    repeat (4) @(posedge clk);
    chk("watchdog reset", t0 + 1, srst);
    rdc(IDX_WDT_MASK_TWO, 8'h00);
    // Converter wake keeps clocks running and resumes on completion
    wr(IDX_WAKE_CTRL, 8'h08);
    ins(instr_t'(5'b00100));
    repeat (2) @(posedge clk);
    chk("clocks with conv wake", 32'h1, {31'h0, clocks_run});
    t0 = rsm;
    ev(event_t'(10'h040));
    repeat (4) @(posedge clk);
    chk("conv awake", 32'h0, {31'h0, sleeping});
    chk("conv resume", t0 + 1, rsm);
    // Converter interrupt on, wake off: flag only, stays asleep
    wr(IDX_WAKE_CTRL, 8'h00);
    wr(IDX_WDT_MASK_TWO, 8'h20);
    ins(instr_t'(5'b00100));
    ev(event_t'(10'h040));
    repeat (4) @(posedge clk);
    chk("conv still asleep", 32'h1, {31'h0, sleeping});
    rdc(IDX_WAKE_CTRL, 8'h20);
    finish_test();
  end
endmodule : wakeup_interrupt_dispatch_tb
